// [design/sgp_ports.sv]
// two shared gpio ports with axi4-lite registers, segment and peripheral muxing
//
// How it works
// - direction one makes the pin an output driven from its data latch
// - direction zero makes the pin an input with the driver released
// - data writes update the latch; output pins show the new value one clock after the latch
// - data writes update latches of input pins too, without driving them
// - normal reads of output bits return the latch contents
// - normal reads of input bits return pin level; rmw reads return the latch
// - peripheral output enable puts its output on the pin; reads see the pin
// - normal reads return pin level even when a peripheral uses the input
// - segment select one then input control one routes the segment signal
// - segment select zero then input control one gives the port path control
// - port e bits 0-1 use segment lines 15:14, bits 2-7 lines 21:16
// - reset clears every direction bit so all pins start as inputs
// - standby with float set: pins hi-z, inputs forced low and blocked; the reset input level still passes unblocked
// - standby with float clear: pin states and driven levels are held
// - open-drain output pin with latch one is released, never driven high
// - port e maps bits 0-7 in order; port f has only bits 0-2
// - port e pins 5,6 share timer 1 outputs, pin 7 its clock input
// - port f pins 0,1 share the main oscillator, pin 2 the reset input
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps

module sgp_ports #(
  parameter logic [sgp_pkg::PF_W-1:0] PF_OPEN_DRAIN = 3'h4
) (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // register bus
  input  wire sgp_pkg::sgp_axi_req_t         axi_req,
  output sgp_pkg::sgp_axi_rsp_t              axi_rsp,
  // port e pins
  input  wire logic [sgp_pkg::PE_W-1:0]      pe_pin_in,
  output logic      [sgp_pkg::PE_W-1:0]      pe_pin_out,
  output logic      [sgp_pkg::PE_W-1:0]      pe_pin_oe,
  // port f pins
  input  wire logic [sgp_pkg::PF_W-1:0]      pf_pin_in,
  output logic      [sgp_pkg::PF_W-1:0]      pf_pin_out,
  output logic      [sgp_pkg::PF_W-1:0]      pf_pin_oe,
  // lcd segment signals for port e bits 0-7
  input  wire logic [sgp_pkg::PE_W-1:0]      lcd_drive_line_level,
  // composite timer 1
  input  wire logic                          timer1_wave_out_a,
  input  wire logic                          timer1_wave_out_a_en,
  input  wire logic                          timer1_wave_out_b,
  input  wire logic                          timer1_wave_out_b_en,
  output logic                               timer1_ext_clock_in,
  // oscillator and reset pin sharing
  input  wire logic                          main_osc_en,
  output logic                               main_osc_in,
  input  wire logic                          reset_pin_en,
  output logic                               reset_pin_level,
  // standby controller: high while in stop or watch mode
  input  wire logic                          standby_mode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sgp_pkg::sgp_state_t st_ff;
  sgp_pkg::sgp_state_t nxt_st;

  logic                     in_block;
  logic [sgp_pkg::PE_W-1:0] pe_lvl;
  logic [sgp_pkg::PF_W-1:0] pf_lvl;
  logic [sgp_pkg::PE_W-1:0] pe_seg;
  logic [sgp_pkg::PE_W-1:0] pe_per_oe;
  logic [sgp_pkg::PE_W-1:0] pe_per_val;
  logic [sgp_pkg::PE_W-1:0] pe_drv_out;
  logic [sgp_pkg::PE_W-1:0] pe_drv_oe;
  logic [sgp_pkg::PE_W-1:0] pe_rd;
  logic [sgp_pkg::PF_W-1:0] pf_owned;
  logic [sgp_pkg::PF_W-1:0] pf_drv_out;
  logic [sgp_pkg::PF_W-1:0] pf_drv_oe;
  logic [sgp_pkg::PF_W-1:0] pf_rd;

  // ----------------------------------------------------------------
  // pin muxing
  // ----------------------------------------------------------------
  // inputs forced low in standby float
  assign in_block = standby_mode & st_ff.standby_pin_float;
  assign pe_lvl   = in_block ? '0 : pe_pin_in;
  assign pf_lvl   = in_block ? '0 : pf_pin_in;

  // segment path needs both select and input control
  assign pe_seg = st_ff.seg_sel & {sgp_pkg::PE_W{st_ff.port_input_control}};

  // timer outputs claim pins 5 and 6
  always_comb begin
    pe_per_oe  = '0;
    pe_per_val = '0;
    pe_per_oe[sgp_pkg::PE_TMR_B_BIT]  = timer1_wave_out_b_en;
    pe_per_val[sgp_pkg::PE_TMR_B_BIT] = timer1_wave_out_b;
    pe_per_oe[sgp_pkg::PE_TMR_A_BIT]  = timer1_wave_out_a_en;
    pe_per_val[sgp_pkg::PE_TMR_A_BIT] = timer1_wave_out_a;
  end

  // oscillator owns pins 0-1, reset function owns pin 2
  // an owner drives the pin itself, so the port driver stays off there
  assign pf_owned = {reset_pin_en, main_osc_en, main_osc_en};

  genvar gi;
  generate
    for (gi = 0; gi < sgp_pkg::PE_W; gi++) begin : g_pe
      // direction or claimant decides the driver
      assign pe_drv_oe[gi] = ~in_block & (pe_seg[gi] |
                             (st_ff.port_input_control & (pe_per_oe[gi] | st_ff.dir_e[gi])));
      // latch reaches the pin only as an output
      assign pe_drv_out[gi] = pe_seg[gi]    ? lcd_drive_line_level[gi] :
                              pe_per_oe[gi] ? pe_per_val[gi] : st_ff.latch_e[gi];
      // latch for plain outputs, pin level otherwise
      assign pe_rd[gi] = (st_ff.dir_e[gi] & ~pe_per_oe[gi] & ~pe_seg[gi]) ?
                         st_ff.latch_e[gi] : pe_lvl[gi];
    end
    for (gi = 0; gi < sgp_pkg::PF_W; gi++) begin : g_pf
      // open-drain bit only ever pulls low
      assign pf_drv_oe[gi] = ~in_block & ~pf_owned[gi] & st_ff.dir_f[gi] &
                             ~(PF_OPEN_DRAIN[gi] & st_ff.latch_f[gi]);
      assign pf_drv_out[gi] = PF_OPEN_DRAIN[gi] ? 1'b0 : st_ff.latch_f[gi];
      assign pf_rd[gi] = st_ff.dir_f[gi] ? st_ff.latch_f[gi] : pf_lvl[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  // pin views come in as arguments so the caller wakes on pin changes
  function automatic logic [sgp_pkg::DATA_W+1:0] rd_decode(
    input logic [sgp_pkg::ADDR_W-1:0] addr,
    input logic [sgp_pkg::PE_W-1:0]   e_rd,
    input logic [sgp_pkg::PF_W-1:0]   f_rd,
    input logic [sgp_pkg::PE_W-1:0]   e_lvl,
    input logic [sgp_pkg::PF_W-1:0]   f_lvl
  );
    logic [sgp_pkg::ADDR_W-1:0] a;
    logic [sgp_pkg::DATA_W-1:0] d;
    logic [1:0]                 r;
    a = {addr[sgp_pkg::ADDR_W-1:2], 2'b00};
    d = '0;
    r = sgp_pkg::RESP_OKAY;
    if (a == sgp_pkg::OFS_E_DATA) begin
      d[sgp_pkg::PE_W-1:0] = e_rd;
    end else if (a == sgp_pkg::OFS_E_DIR) begin
      d[sgp_pkg::PE_W-1:0] = st_ff.dir_e;
    end else if (a == sgp_pkg::OFS_F_DATA) begin
      d[sgp_pkg::PF_W-1:0] = f_rd;
    end else if (a == sgp_pkg::OFS_F_DIR) begin
      d[sgp_pkg::PF_W-1:0] = st_ff.dir_f;
    end else if (a == sgp_pkg::OFS_E_RMW) begin
      // rmw view returns the latch
      // the bus carries no rmw flag, so the latch view has its own offset
      d[sgp_pkg::PE_W-1:0] = st_ff.latch_e;
    end else if (a == sgp_pkg::OFS_F_RMW) begin
      d[sgp_pkg::PF_W-1:0] = st_ff.latch_f;
    end else if (a == sgp_pkg::OFS_LCD_CTRL) begin
      d[sgp_pkg::PE_W-1:0]          = st_ff.seg_sel;
      d[sgp_pkg::CTRL_PORT_INPUT_CONTROL_BIT]    = st_ff.port_input_control;
      d[sgp_pkg::CTRL_SPL_BIT]      = st_ff.standby_pin_float;
    end else if (a == sgp_pkg::OFS_PIN_STAT) begin
      d[sgp_pkg::PE_W-1:0] = e_lvl;
      d[sgp_pkg::STAT_PF_LSB +: sgp_pkg::PF_W] = f_lvl;
    end else begin
      r = sgp_pkg::RESP_SLVERR;
    end
    return {r, d};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [sgp_pkg::ADDR_W-1:0] wa;
    logic                       wb0;
    logic                       wb1;
    logic [sgp_pkg::DATA_W+1:0] rd;
    nxt_st = st_ff;
    wa     = '0;
    wb0    = 1'b0;
    wb1    = 1'b0;
    rd     = '0;

    // write address and data taken in either order
    if (axi_req.awvalid && st_ff.rsp.awready) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_ff.rsp.wready) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.w_data = axi_req.wdata;
      nxt_st.w_strb = axi_req.wstrb;
    end

    case (st_ff.wr_st)
      sgp_pkg::WR_IDLE: begin
        if (nxt_st.aw_got && nxt_st.w_got) begin
          wa  = {nxt_st.aw_addr[sgp_pkg::ADDR_W-1:2], 2'b00};
          wb0 = nxt_st.w_strb[0];
          wb1 = nxt_st.w_strb[1];
          nxt_st.rsp.bresp = sgp_pkg::RESP_OKAY;
          if (wa == sgp_pkg::OFS_E_DATA || wa == sgp_pkg::OFS_E_RMW) begin
            if (wb0) begin
              nxt_st.latch_e = nxt_st.w_data[sgp_pkg::PE_W-1:0];
            end
          end else if (wa == sgp_pkg::OFS_E_DIR) begin
            if (wb0) begin
              nxt_st.dir_e = nxt_st.w_data[sgp_pkg::PE_W-1:0];
            end
          end else if (wa == sgp_pkg::OFS_F_DATA || wa == sgp_pkg::OFS_F_RMW) begin
            if (wb0) begin
              nxt_st.latch_f = nxt_st.w_data[sgp_pkg::PF_W-1:0];
            end
          end else if (wa == sgp_pkg::OFS_F_DIR) begin
            if (wb0) begin
              nxt_st.dir_f = nxt_st.w_data[sgp_pkg::PF_W-1:0];
            end
          end else if (wa == sgp_pkg::OFS_LCD_CTRL) begin
            // low two lines from enable four, upper six from enable five
            if (wb0) begin
              nxt_st.seg_sel[sgp_pkg::CTRL_SEG4_LSB +: sgp_pkg::CTRL_SEG4_W] =
                nxt_st.w_data[sgp_pkg::CTRL_SEG4_LSB +: sgp_pkg::CTRL_SEG4_W];
              nxt_st.seg_sel[sgp_pkg::CTRL_SEG5_LSB +: sgp_pkg::CTRL_SEG5_W] =
                nxt_st.w_data[sgp_pkg::CTRL_SEG5_LSB +: sgp_pkg::CTRL_SEG5_W];
            end
            // input control and standby float come from byte one, on the same clock as select
            if (wb1) begin
              nxt_st.port_input_control = nxt_st.w_data[sgp_pkg::CTRL_PORT_INPUT_CONTROL_BIT];
              nxt_st.standby_pin_float   = nxt_st.w_data[sgp_pkg::CTRL_SPL_BIT];
            end
          end else if (wa != sgp_pkg::OFS_PIN_STAT) begin
            nxt_st.rsp.bresp = sgp_pkg::RESP_SLVERR;
          end
          nxt_st.aw_got     = 1'b0;
          nxt_st.w_got      = 1'b0;
          nxt_st.rsp.bvalid = 1'b1;
          nxt_st.wr_st      = sgp_pkg::WR_RESP;
        end
      end
      sgp_pkg::WR_RESP: begin
        if (axi_req.bready) begin
          nxt_st.rsp.bvalid = 1'b0;
          nxt_st.wr_st      = sgp_pkg::WR_IDLE;
        end
      end
      default: begin
        nxt_st.wr_st = sgp_pkg::WR_IDLE;
      end
    endcase
    // ready only while a slot is free, so nothing is taken twice
    nxt_st.rsp.awready = ~nxt_st.aw_got & (nxt_st.wr_st == sgp_pkg::WR_IDLE);
    nxt_st.rsp.wready  = ~nxt_st.w_got & (nxt_st.wr_st == sgp_pkg::WR_IDLE);

    case (st_ff.rd_st)
      sgp_pkg::RD_IDLE: begin
        if (axi_req.arvalid && st_ff.rsp.arready) begin
          rd                = rd_decode(axi_req.araddr, pe_rd, pf_rd,
                                        pe_lvl, pf_lvl);
          nxt_st.rsp.rresp  = rd[sgp_pkg::DATA_W+1:sgp_pkg::DATA_W];
          nxt_st.rsp.rdata  = rd[sgp_pkg::DATA_W-1:0];
          nxt_st.rsp.rvalid = 1'b1;
          nxt_st.rd_st      = sgp_pkg::RD_DATA;
        end
      end
      sgp_pkg::RD_DATA: begin
        if (axi_req.rready) begin
          nxt_st.rsp.rvalid = 1'b0;
          nxt_st.rd_st      = sgp_pkg::RD_IDLE;
        end
      end
      default: begin
        nxt_st.rd_st = sgp_pkg::RD_IDLE;
      end
    endcase
    nxt_st.rsp.arready = (nxt_st.rd_st == sgp_pkg::RD_IDLE);

    // float clear: standby freezes pins as they stand
    if (!(standby_mode && !st_ff.standby_pin_float)) begin
      nxt_st.pe_out  = pe_drv_out;
      nxt_st.pe_oe   = pe_drv_oe;
      nxt_st.pf_out  = pf_drv_out;
      nxt_st.pf_oe   = pf_drv_oe;
      // clock input seen through the blocked pin level
      nxt_st.ext_clk = pe_lvl[sgp_pkg::PE_EXT_CLK_BIT];
      nxt_st.osc_in  = pf_lvl[0];
    end
    // reset function keeps watching its pin in every mode
    nxt_st.rst_lvl = pf_pin_in[sgp_pkg::PF_RST_BIT];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.wr_st   <= sgp_pkg::WR_IDLE;
      st_ff.rd_st   <= sgp_pkg::RD_IDLE;
      st_ff.aw_got  <= 1'b0;
      st_ff.aw_addr <= '0;
      st_ff.w_got   <= 1'b0;
      st_ff.w_data  <= '0;
      st_ff.w_strb  <= '0;
      st_ff.rsp     <= '0;
      st_ff.latch_e <= sgp_pkg::RST_LATCH_E;
      st_ff.dir_e   <= sgp_pkg::RST_DIR_E;
      st_ff.latch_f <= sgp_pkg::RST_LATCH_F;
      st_ff.dir_f   <= sgp_pkg::RST_DIR_F;
      st_ff.seg_sel <= sgp_pkg::RST_SEG_SEL;
      st_ff.port_input_control   <= sgp_pkg::RST_PORT_INPUT_CONTROL;
      st_ff.standby_pin_float     <= sgp_pkg::RST_SPL;
      st_ff.pe_out  <= '0;
      st_ff.pe_oe   <= '0;
      st_ff.pf_out  <= '0;
      st_ff.pf_oe   <= '0;
      st_ff.ext_clk <= 1'b0;
      st_ff.osc_in  <= 1'b0;
      st_ff.rst_lvl <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  // bit i of each register drives pin i
  assign axi_rsp             = st_ff.rsp;
  assign pe_pin_out          = st_ff.pe_out;
  assign pe_pin_oe           = st_ff.pe_oe;
  assign pf_pin_out          = st_ff.pf_out;
  assign pf_pin_oe           = st_ff.pf_oe;
  assign timer1_ext_clock_in = st_ff.ext_clk;
  assign main_osc_in         = st_ff.osc_in;
  assign reset_pin_level     = st_ff.rst_lvl;

endmodule

// [design/sgp_pkg.sv]
// shared constants, bus carriers and state record for the shared gpio ports
package sgp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PE_W   = 8;
  localparam int PF_W   = 3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_E_DATA   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_E_DIR    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_F_DATA   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_F_DIR    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_E_RMW    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_F_RMW    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LCD_CTRL = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PIN_STAT = 8'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SEG4_LSB  = 0;
  localparam int CTRL_SEG4_W    = 2;
  localparam int CTRL_SEG5_LSB  = 2;
  localparam int CTRL_SEG5_W    = 6;
  localparam int CTRL_PORT_INPUT_CONTROL_BIT = 8;
  localparam int CTRL_SPL_BIT   = 9;
  localparam int STAT_PF_LSB    = 8;
  localparam int PE_TMR_B_BIT   = 5;
  localparam int PE_TMR_A_BIT   = 6;
  localparam int PE_EXT_CLK_BIT = 7;
  localparam int PF_OSC_LAST    = 1;
  localparam int PF_RST_BIT     = 2;

  // ----------------------------------------------------------------
  // reset values and answers
  // ----------------------------------------------------------------
  localparam logic [PE_W-1:0] RST_LATCH_E = 8'h00;
  localparam logic [PE_W-1:0] RST_DIR_E   = 8'h00;
  localparam logic [PF_W-1:0] RST_LATCH_F = 3'h0;
  localparam logic [PF_W-1:0] RST_DIR_F   = 3'h0;
  localparam logic [PE_W-1:0] RST_SEG_SEL = 8'h00;
  localparam logic            RST_PORT_INPUT_CONTROL   = 1'b1;
  localparam logic            RST_SPL     = 1'b0;
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} sgp_wr_st_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} sgp_rd_st_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } sgp_axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } sgp_axi_rsp_t;

  typedef struct packed {
    sgp_wr_st_t        wr_st;
    sgp_rd_st_t        rd_st;
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    sgp_axi_rsp_t      rsp;
    logic [PE_W-1:0]   latch_e;
    logic [PE_W-1:0]   dir_e;
    logic [PF_W-1:0]   latch_f;
    logic [PF_W-1:0]   dir_f;
    logic [PE_W-1:0]   seg_sel;
    logic              port_input_control;
    logic              standby_pin_float;
    logic [PE_W-1:0]   pe_out;
    logic [PE_W-1:0]   pe_oe;
    logic [PF_W-1:0]   pf_out;
    logic [PF_W-1:0]   pf_oe;
    logic              ext_clk;
    logic              osc_in;
    logic              rst_lvl;
  } sgp_state_t;

endpackage

// [sim/sgp_board_model.sv]
// board circuitry model that resolves the port pin levels
`timescale 1ns/10ps

module sgp_board_model (
  // device drive
  input  wire logic [sgp_pkg::PE_W-1:0] pe_pin_out,
  input  wire logic [sgp_pkg::PE_W-1:0] pe_pin_oe,
  input  wire logic [sgp_pkg::PF_W-1:0] pf_pin_out,
  input  wire logic [sgp_pkg::PF_W-1:0] pf_pin_oe,
  // board drive levels
  input  wire logic [sgp_pkg::PE_W-1:0] ext_e,
  input  wire logic [sgp_pkg::PF_W-1:0] ext_f,
  // resolved levels
  output logic      [sgp_pkg::PE_W-1:0] pe_pin_in,
  output logic      [sgp_pkg::PF_W-1:0] pf_pin_in
);
  assign pe_pin_in = (pe_pin_oe & pe_pin_out) | (~pe_pin_oe & ext_e);
  assign pf_pin_in = (pf_pin_oe & pf_pin_out) | (~pf_pin_oe & ext_f);
endmodule

// [sim/sgp_ports_checker.sv]
// concurrent checks on the shared gpio port pins and register bus
`timescale 1ns/10ps

module sgp_ports_checker #(
  parameter logic [sgp_pkg::PF_W-1:0] PF_OPEN_DRAIN = 3'h4
) (
  // clock and reset
  input wire logic                     core_clk,
  input wire logic                     rst_n,
  // register bus
  input wire sgp_pkg::sgp_axi_req_t    axi_req,
  input wire sgp_pkg::sgp_axi_rsp_t    axi_rsp,
  // pins
  input wire logic [sgp_pkg::PE_W-1:0] pe_pin_in,
  input wire logic [sgp_pkg::PE_W-1:0] pe_pin_oe,
  input wire logic [sgp_pkg::PF_W-1:0] pf_pin_in,
  input wire logic [sgp_pkg::PF_W-1:0] pf_pin_out,
  input wire logic [sgp_pkg::PF_W-1:0] pf_pin_oe,
  // peripheral copies and standby
  input wire logic                     timer1_ext_clock_in,
  input wire logic                     main_osc_in,
  input wire logic                     reset_pin_level,
  input wire logic                     standby_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  wr_resp_lat_a: assert property (
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |=> axi_rsp.bvalid)
    else $error("write response not one cycle after handshake");
  rd_resp_lat_a: assert property (
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer not one cycle after address");
  rd_refuse_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("address accepted while read data pending");
  reset_inputs_a: assert property (
    $rose(rst_n) |-> ##1 (pe_pin_oe == 8'h00 && pf_pin_oe == 3'h0))
    else $error("pin driven right after reset");
  standby_hold_a: assert property (
    standby_mode && $past(standby_mode) |-> (pe_pin_oe == 8'h00 || $stable(pe_pin_oe)))
    else $error("pin enables moved in standby");
  ext_clk_copy_a: assert property (
    $past(rst_n) && !$past(standby_mode) |-> timer1_ext_clock_in == $past(pe_pin_in[7]))
    else $error("timer clock input not the pin level");
  osc_copy_a: assert property (
    $past(rst_n) && !$past(standby_mode) |-> main_osc_in == $past(pf_pin_in[0]))
    else $error("oscillator input not the pin level");
  rst_level_a: assert property (
    $past(rst_n) && !$past(standby_mode) |-> reset_pin_level == $past(pf_pin_in[2]))
    else $error("reset input not the pin level");
  open_drain_a: assert property (
    |(pf_pin_oe & PF_OPEN_DRAIN) |-> (pf_pin_out & PF_OPEN_DRAIN) == 3'h0)
    else $error("open drain pin driven high");

  cover property (axi_rsp.bvalid && axi_rsp.bresp == 2'h2);
  cover property (standby_mode && pe_pin_oe != 8'h00);
  cover property (pf_pin_oe[2]);
endmodule

bind sgp_ports sgp_ports_checker #(.PF_OPEN_DRAIN(PF_OPEN_DRAIN)) sgp_ports_checker_i (
  .core_clk(core_clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .pe_pin_in(pe_pin_in), .pe_pin_oe(pe_pin_oe), .pf_pin_in(pf_pin_in),
  .pf_pin_out(pf_pin_out), .pf_pin_oe(pf_pin_oe), .timer1_ext_clock_in(timer1_ext_clock_in),
  .main_osc_in(main_osc_in), .reset_pin_level(reset_pin_level), .standby_mode(standby_mode));

// [sim/tb.sv]
// self-checking bench for the shared gpio ports
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module tb;
  logic                  core_clk, rst_n, std, osc_en, rst_en;
  logic                  t_a, t_a_en, t_b, t_b_en, ext_clk, osc_in, rst_lvl;
  sgp_pkg::sgp_axi_req_t req;
  sgp_pkg::sgp_axi_rsp_t rsp;
  logic [7:0]            pe_in, pe_out, pe_oe, ext_e, lcd_drive_line_select;
  logic [2:0]            pf_in, pf_out, pf_oe, ext_f;
  logic [31:0]           rd_d;
  logic [1:0]            rsp_c;
  int                    n_errors, samples_checked, cycles;

  sgp_ports sgp_ports_i (.core_clk(core_clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
    .pe_pin_in(pe_in), .pe_pin_out(pe_out), .pe_pin_oe(pe_oe), .pf_pin_in(pf_in),
    .pf_pin_out(pf_out), .pf_pin_oe(pf_oe), .lcd_drive_line_level(lcd_drive_line_select),
    .timer1_wave_out_a(t_a), .timer1_wave_out_a_en(t_a_en), .timer1_wave_out_b(t_b),
    .timer1_wave_out_b_en(t_b_en), .timer1_ext_clock_in(ext_clk), .main_osc_en(osc_en),
    .main_osc_in(osc_in), .reset_pin_en(rst_en), .reset_pin_level(rst_lvl),
    .standby_mode(std));
  sgp_board_model sgp_board_model_i (.pe_pin_out(pe_out), .pe_pin_oe(pe_oe),
    .pf_pin_out(pf_out), .pf_pin_oe(pf_oe), .ext_e(ext_e), .ext_f(ext_f),
    .pe_pin_in(pe_in), .pf_pin_in(pf_in));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----
  // bus tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    rsp_c = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd_d = rsp.rdata;
    rsp_c = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_d, e)
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // hang guard well above the sequence length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ----
  // sequence
  // ----
  initial begin
    {rst_n, std, osc_en, rst_en, t_a, t_a_en, t_b, t_b_en} = '0;
    req = '0;
    ext_e = 8'hA5;
    ext_f = 3'h5;
    lcd_drive_line_select = 8'h82;
    n_errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rc(sgp_pkg::OFS_E_DIR, 32'h0);
    rc(sgp_pkg::OFS_F_DIR, 32'h0);
    rc(sgp_pkg::OFS_LCD_CTRL, 32'h100);
    wr(sgp_pkg::OFS_E_DATA, 32'h3C);
    wt(2);
    `CHK(pe_oe, 8'h00)
    wr(sgp_pkg::OFS_E_DIR, 32'h0F);
    wt(2);
    `CHK(pe_oe, 8'h0F)
    `CHK(pe_out[3:0], 4'hC)
    rc(sgp_pkg::OFS_E_DATA, 32'hAC);
    rc(sgp_pkg::OFS_E_RMW, 32'h3C);
    wr(sgp_pkg::OFS_F_DIR, 32'hFF);
    rc(sgp_pkg::OFS_F_DIR, 32'h7);
    wr(sgp_pkg::OFS_F_DATA, 32'hFF);
    rc(sgp_pkg::OFS_F_RMW, 32'h7);
    wt(2);
    `CHK(pf_oe, 3'h3)
    wr(sgp_pkg::OFS_F_DATA, 32'h3);
    wt(2);
    `CHK(pf_oe, 3'h7)
    `CHK(pf_out, 3'h3)
    osc_en <= 1'b1;
    rst_en <= 1'b1;
    wt(3);
    `CHK(pf_oe, 3'h0)
    `CHK({osc_in, rst_lvl}, 2'h3)
    osc_en <= 1'b0;
    rst_en <= 1'b0;
    wr(sgp_pkg::OFS_F_DIR, 32'h0);
    rc(sgp_pkg::OFS_F_DATA, 32'h5);
    // segment routing: direction off, select, then input control
    wr(sgp_pkg::OFS_E_DIR, 32'h0);
    wr(sgp_pkg::OFS_LCD_CTRL, 32'h83);
    wt(2);
    `CHK(pe_oe, 8'h00)
    wr(sgp_pkg::OFS_LCD_CTRL, 32'h183);
    wt(2);
    `CHK(pe_oe, 8'h83)
    `CHK(pe_out & 8'h83, 8'h82)
    wr(sgp_pkg::OFS_LCD_CTRL, 32'h0);
    wr(sgp_pkg::OFS_LCD_CTRL, 32'h100);
    wr(sgp_pkg::OFS_E_DIR, 32'h3);
    wt(2);
    `CHK(pe_oe, 8'h03)
    t_a <= 1'b1;
    t_a_en <= 1'b1;
    t_b_en <= 1'b1;
    wt(2);
    `CHK(pe_oe, 8'h63)
    `CHK(pe_out[6:5], 2'b10)
    rc(sgp_pkg::OFS_E_DATA, 32'hC4);
    rc(sgp_pkg::OFS_E_RMW, 32'h3C);
    `CHK(ext_clk, 1'b1)
    // peripheral outputs off before the unmapped offset checks
    t_a_en <= 1'b0;
    t_b_en <= 1'b0;
    rd(8'h20);
    `CHK(rsp_c, sgp_pkg::RESP_SLVERR)
    `CHK(rd_d, 32'h0)
    wr(8'h20, 32'h1);
    `CHK(rsp_c, sgp_pkg::RESP_SLVERR)
    std <= 1'b1;
    t_a_en <= 1'b1;
    wt(3);
    `CHK(pe_oe, 8'h03)
    `CHK(pe_out[6], 1'b0)
    std <= 1'b0;
    t_a_en <= 1'b0;
    wr(sgp_pkg::OFS_LCD_CTRL, 32'h300);
    std <= 1'b1;
    wt(3);
    `CHK({pe_oe, pf_oe}, 11'h0)
    `CHK(ext_clk, 1'b0)
    rc(sgp_pkg::OFS_PIN_STAT, 32'h0);
    std <= 1'b0;
    wt(2);
    give_verdict();
  end
endmodule
